//--- acc_pkg.sv
// Purpose: Shared constants for the converter control block.
// Assumes: Registers are word indexed; byte address is four times the index.
// Notes:   Register widths are 8 bits except threshold and result.
package acc_pkg;
    localparam int ACC_RES_W  = 12;
    localparam int ACC_DLY_W  = 9;
    localparam int ACC_ADDR_W = 10;

    localparam logic [7:0] ACC_IDX_CTL_ONE  = 8'hE1;
    localparam logic [7:0] ACC_IDX_CTL_TWO  = 8'hE2;
    localparam logic [7:0] ACC_IDX_DLY_LOW  = 8'hE3;
    localparam logic [7:0] ACC_IDX_CTL_ZERO = 8'hE8;
    localparam logic [7:0] ACC_IDX_THRESH   = 8'hF0;
    localparam logic [7:0] ACC_IDX_RESULT   = 8'hF1;
    localparam logic [7:0] ACC_IDX_IRQ_STAT = 8'hF2;
    localparam logic [7:0] ACC_IDX_IRQ_MASK = 8'hF3;

    localparam int ACC_C2_BRAKE_EN = 7;
    localparam int ACC_C2_POL      = 6;
    localparam int ACC_C2_CMP_EN   = 5;
    localparam int ACC_C2_CMP_RES  = 4;
    localparam int ACC_C2_DLY_HI   = 0;
    localparam int ACC_C0_DONE     = 7;
    localparam int ACC_C0_BUSY     = 6;
    localparam int ACC_C0_SRC_LSB  = 4;
    localparam int ACC_C0_CHAN_LSB = 0;
    localparam int ACC_C1_TYPE_LSB = 2;
    localparam int ACC_C1_EXT_EN   = 1;
    localparam int ACC_C1_PWR      = 0;
    localparam int ACC_IRQ_DONE    = 0;
    localparam int ACC_IRQ_HIT     = 1;

    localparam logic [7:0]  ACC_RST_BYTE  = 8'h00;
    localparam logic [31:0] ACC_RST_WORD  = 32'h0000_0000;
    localparam logic [3:0]  ACC_CHAN_BGAP = 4'h8;

    localparam logic [1:0] ACC_SRC_PWM_CHANNEL_ZERO = 2'h0;
    localparam logic [1:0] ACC_SRC_PWM_CHANNEL_TWO = 2'h1;
    localparam logic [1:0] ACC_SRC_PWM_CHANNEL_FOUR = 2'h2;
    localparam logic [1:0] ACC_SRC_PIN  = 2'h3;
    localparam logic [1:0] ACC_TYP_FALL = 2'h0;
    localparam logic [1:0] ACC_TYP_RISE = 2'h1;
    localparam logic [1:0] ACC_TYP_CTR  = 2'h2;
    localparam logic [1:0] ACC_TYP_END  = 2'h3;

    localparam logic [1:0] ACC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ACC_IDLE, ACC_DELAY, ACC_CONV} acc_fsm_t;
endpackage : acc_pkg

//--- acc_conversion_control.sv
// Purpose: Converter start, trigger delay, result compare and brake control.
// Assumes: All inputs synchronous to aclk; converter pulses done once per start.
// Notes:   AXI4-Lite slave, one write and one read outstanding.
// Overview of operation
// (R1) Compare hit with brake enable asserts fault brake.
// (R2) Polarity 0 means greater-equal, 1 means less.
// (R3) Comparator works only when enabled.
// (R4) Compare result read-only, updated per conversion.
// (R5) Nine-bit delay holds off externally triggered start.
// (R6) Done flag set by hardware, cleared by software.
// (R7) No conversion starts while done flag set.
// (R8) Writing one to busy bit starts; zero ignored.
// (R9) Busy bit reads one until conversion completes.
// (R10) Source field picks PWM zero, two, four, pin.
// (R11) Channel field routes inputs or band-gap reference.
// (R12) Power off disconnects every analog input.
// (R13) External trigger starts only when enabled.
// (R14) Type field picks falling, rising, centre, end.
// (R15) External triggers ignored while busy.
// (R16) Power bit switches converter on and off.
// (R17) Delay counts clocks; zero starts next cycle.
// (R18) Fault brake is a single-cycle pulse.
`timescale 1ns/1ps
module acc_conversion_control
#(
    parameter int RES_W = acc_pkg::ACC_RES_W,
    parameter int DLY_W = acc_pkg::ACC_DLY_W
)
(
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [acc_pkg::ACC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [acc_pkg::ACC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          pwm_channel_zero,
    input  wire logic                          pwm_channel_two,
    input  wire logic                          pwm_channel_four,
    input  wire logic                          ext_start_pin,
    input  wire logic                          pwm_centre_point,
    input  wire logic                          pwm_end_point,
    input  wire logic                          conv_complete,
    input  wire logic [RES_W-1:0]              conversion_result,
    output logic                               conv_start,
    output logic                               converter_power_on,
    output logic [3:0]                         input_channel_select,
    output logic                               input_connect,
    output logic                               fault_brake,
    output logic                               irq
);
    import acc_pkg::*;

    if (RES_W < 9 || RES_W > 16 || DLY_W != ACC_DLY_W)
    begin : g_bad_param
        $error("acc_conversion_control: unsupported width parameter");
    end

    typedef struct packed {
        acc_fsm_t                fsm;
        logic [DLY_W-1:0]        dly_cnt;
        logic                    src_prev;
        logic                    brake_en;
        logic                    pol;
        logic                    cmp_en;
        logic                    cmp_res;
        logic [DLY_W-1:0]        dly;
        logic                    done;
        logic                    busy;
        logic [1:0]              src;
        logic [3:0]              chan;
        logic [1:0]              trig_type;
        logic                    ext_en;
        logic                    pwr;
        logic [RES_W-1:0]        thresh;
        logic [RES_W-1:0]        result;
        logic [1:0]              irq_stat;
        logic [1:0]              irq_mask;
        logic                    aw_full;
        logic [ACC_ADDR_W-1:0]   aw_addr;
        logic                    w_full;
        logic [31:0]             wdata;
        logic [3:0]              wstrb;
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
        logic                    irq;
        logic                    conv_start;
        logic                    connect;
        logic                    fault_brake;
    } acc_state_t;

    localparam acc_state_t ST_RST = '0;

    acc_state_t s_r;
    acc_state_t s_nxt;
    logic       src_sel;
    logic       trig_hit;
    logic       trig_fire;
    logic       sw_start;
    logic       can_start;
    logic       wr_go;
    logic       hit;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;
    logic       wr_map;
    logic       rd_map;

    assign wr_idx = s_r.aw_addr[9:2];
    assign rd_idx = s_axi_araddr[9:2];
    assign wr_go  = s_r.aw_full && s_r.w_full && !s_r.bvalid;

    // Only the low byte lane carries the 8-bit control registers.
    assign wr_map = wr_idx inside {ACC_IDX_CTL_ONE, ACC_IDX_CTL_TWO, ACC_IDX_DLY_LOW,
                                   ACC_IDX_CTL_ZERO, ACC_IDX_THRESH, ACC_IDX_IRQ_MASK};
    assign rd_map = rd_idx inside {ACC_IDX_CTL_ONE, ACC_IDX_CTL_TWO, ACC_IDX_DLY_LOW,
                                   ACC_IDX_CTL_ZERO, ACC_IDX_THRESH, ACC_IDX_RESULT,
                                   ACC_IDX_IRQ_STAT, ACC_IDX_IRQ_MASK};

    // (R8) software start request
    assign sw_start = wr_go && s_r.wstrb[0] && (wr_idx == ACC_IDX_CTL_ZERO)
                      && s_r.wdata[ACC_C0_BUSY];

    // (R7) done flag blocks starts
    assign can_start = s_r.pwr && !s_r.done;

    // (R10) trigger source mux
    always_comb
    begin
        case (s_r.src)
            ACC_SRC_PWM_CHANNEL_ZERO: src_sel = pwm_channel_zero;
            ACC_SRC_PWM_CHANNEL_TWO: src_sel = pwm_channel_two;
            ACC_SRC_PWM_CHANNEL_FOUR: src_sel = pwm_channel_four;
            default:      src_sel = ext_start_pin;
        endcase
    end

    // (R14) trigger condition select
    always_comb
    begin
        case (s_r.trig_type)
            ACC_TYP_FALL: trig_hit = s_r.src_prev && !src_sel;
            ACC_TYP_RISE: trig_hit = !s_r.src_prev && src_sel;
            ACC_TYP_CTR:  trig_hit = pwm_centre_point;
            default:      trig_hit = pwm_end_point;
        endcase
    end

    // (R13) external trigger gate; (R15) busy blocks it
    assign trig_fire = s_r.ext_en && trig_hit && !s_r.busy && can_start;

    // (R2) polarity compare; (R3) enable gate
    assign hit = s_r.cmp_en && (s_r.pol ? (conversion_result < s_r.thresh)
                                        : (conversion_result >= s_r.thresh));

    always_comb
    begin
        s_nxt             = s_r;
        s_nxt.conv_start  = 1'b0;
        // (R18) brake pulse defaults low
        s_nxt.fault_brake = 1'b0;
        s_nxt.src_prev    = src_sel;

        if (s_r.rvalid && s_axi_rready)
        begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_r.arready && s_axi_arvalid)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = rd_map ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
            s_nxt.rdata  = ACC_RST_WORD;
            case (rd_idx)
                ACC_IDX_CTL_ONE:
                begin
                    s_nxt.rdata[ACC_C1_TYPE_LSB +: 2] = s_r.trig_type;
                    s_nxt.rdata[ACC_C1_EXT_EN]        = s_r.ext_en;
                    s_nxt.rdata[ACC_C1_PWR]           = s_r.pwr;
                end
                ACC_IDX_CTL_TWO:
                begin
                    s_nxt.rdata[ACC_C2_BRAKE_EN] = s_r.brake_en;
                    s_nxt.rdata[ACC_C2_POL]      = s_r.pol;
                    s_nxt.rdata[ACC_C2_CMP_EN]   = s_r.cmp_en;
                    s_nxt.rdata[ACC_C2_CMP_RES]  = s_r.cmp_res;
                    s_nxt.rdata[ACC_C2_DLY_HI]   = s_r.dly[DLY_W-1];
                end
                ACC_IDX_DLY_LOW:  s_nxt.rdata[7:0] = s_r.dly[7:0];
                ACC_IDX_CTL_ZERO:
                begin
                    s_nxt.rdata[ACC_C0_DONE]         = s_r.done;
                    s_nxt.rdata[ACC_C0_BUSY]         = s_r.busy;
                    s_nxt.rdata[ACC_C0_SRC_LSB +: 2] = s_r.src;
                    s_nxt.rdata[ACC_C0_CHAN_LSB +: 4] = s_r.chan;
                end
                ACC_IDX_THRESH:   s_nxt.rdata[RES_W-1:0] = s_r.thresh;
                ACC_IDX_RESULT:   s_nxt.rdata[RES_W-1:0] = s_r.result;
                ACC_IDX_IRQ_STAT:
                begin
                    s_nxt.rdata[1:0] = s_r.irq_stat;
                    s_nxt.irq_stat   = 2'h0;
                end
                ACC_IDX_IRQ_MASK: s_nxt.rdata[1:0] = s_r.irq_mask;
                default:          s_nxt.rdata = ACC_RST_WORD;
            endcase
        end

        if (s_r.awready && s_axi_awvalid)
        begin
            s_nxt.aw_full = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_r.wready && s_axi_wvalid)
        begin
            s_nxt.w_full = 1'b1;
            s_nxt.wdata  = s_axi_wdata;
            s_nxt.wstrb  = s_axi_wstrb;
        end
        if (s_r.bvalid && s_axi_bready)
        begin
            s_nxt.bvalid = 1'b0;
        end
        if (wr_go)
        begin
            s_nxt.aw_full = 1'b0;
            s_nxt.w_full  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = wr_map ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
            if (s_r.wstrb[0])
            begin
                case (wr_idx)
                    ACC_IDX_CTL_ONE:
                    begin
                        s_nxt.trig_type = s_r.wdata[ACC_C1_TYPE_LSB +: 2];
                        s_nxt.ext_en    = s_r.wdata[ACC_C1_EXT_EN];
                        // (R16) power switch
                        s_nxt.pwr       = s_r.wdata[ACC_C1_PWR];
                    end
                    ACC_IDX_CTL_TWO:
                    begin
                        s_nxt.brake_en     = s_r.wdata[ACC_C2_BRAKE_EN];
                        s_nxt.pol          = s_r.wdata[ACC_C2_POL];
                        s_nxt.cmp_en       = s_r.wdata[ACC_C2_CMP_EN];
                        s_nxt.dly[DLY_W-1] = s_r.wdata[ACC_C2_DLY_HI];
                    end
                    ACC_IDX_DLY_LOW: s_nxt.dly[7:0] = s_r.wdata[7:0];
                    ACC_IDX_CTL_ZERO:
                    begin
                        // (R6) software may only clear done
                        s_nxt.done = s_r.done && s_r.wdata[ACC_C0_DONE];
                        s_nxt.src  = s_r.wdata[ACC_C0_SRC_LSB +: 2];
                        // (R11) channel routing code
                        s_nxt.chan = s_r.wdata[ACC_C0_CHAN_LSB +: 4];
                    end
                    ACC_IDX_THRESH:   s_nxt.thresh[7:0] = s_r.wdata[7:0];
                    ACC_IDX_IRQ_MASK: s_nxt.irq_mask = s_r.wdata[1:0];
                    default:          s_nxt.irq_mask = s_r.irq_mask;
                endcase
            end
            if (s_r.wstrb[1] && (wr_idx == ACC_IDX_THRESH))
            begin
                s_nxt.thresh[RES_W-1:8] = s_r.wdata[RES_W-1:8];
            end
        end

        case (s_r.fsm)
            ACC_IDLE:
            begin
                if (sw_start && can_start)
                begin
                    s_nxt.conv_start = 1'b1;
                    s_nxt.busy       = 1'b1;
                    s_nxt.fsm        = ACC_CONV;
                end
                else if (trig_fire)
                begin
                    s_nxt.busy = 1'b1;
                    // (R17) zero delay starts on the next cycle
                    if (s_r.dly == '0)
                    begin
                        s_nxt.conv_start = 1'b1;
                        s_nxt.fsm        = ACC_CONV;
                    end
                    else
                    begin
                        s_nxt.dly_cnt = s_r.dly - 1'b1;
                        s_nxt.fsm     = ACC_DELAY;
                    end
                end
            end
            ACC_DELAY:
            begin
                // (R5) count out the trigger delay
                if (!s_r.pwr)
                begin
                    s_nxt.busy = 1'b0;
                    s_nxt.fsm  = ACC_IDLE;
                end
                else if (sw_start || s_r.dly_cnt == '0)
                begin
                    s_nxt.conv_start = 1'b1;
                    s_nxt.fsm        = ACC_CONV;
                end
                else
                begin
                    s_nxt.dly_cnt = s_r.dly_cnt - 1'b1;
                end
            end
            ACC_CONV:
            begin
                // A converter switched off never answers, so the wait is dropped.
                if (!s_r.pwr)
                begin
                    s_nxt.busy = 1'b0;
                    s_nxt.fsm  = ACC_IDLE;
                end
                else if (conv_complete)
                begin
                    // (R9) busy clears at completion
                    s_nxt.busy    = 1'b0;
                    s_nxt.fsm     = ACC_IDLE;
                    // (R6) completion sets done, winning over a clear
                    s_nxt.done    = 1'b1;
                    s_nxt.result  = conversion_result;
                    // (R4) compare bit refreshed per conversion
                    s_nxt.cmp_res = hit;
                    s_nxt.irq_stat[ACC_IRQ_DONE] = 1'b1;
                    // (R1) brake request on compare hit
                    if (hit && s_r.brake_en)
                    begin
                        s_nxt.fault_brake = 1'b1;
                        s_nxt.irq_stat[ACC_IRQ_HIT] = 1'b1;
                    end
                end
            end
            default: s_nxt.fsm = ACC_IDLE;
        endcase

        // (R12) power off disconnects inputs
        s_nxt.connect = s_nxt.pwr && (s_nxt.chan <= ACC_CHAN_BGAP);
        s_nxt.irq     = |(s_nxt.irq_stat & s_nxt.irq_mask);
        s_nxt.awready = !s_nxt.aw_full;
        s_nxt.wready  = !s_nxt.w_full;
        s_nxt.arready = !s_nxt.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_r <= ST_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready        = s_r.awready;
    assign s_axi_wready         = s_r.wready;
    assign s_axi_bvalid         = s_r.bvalid;
    assign s_axi_bresp          = s_r.bresp;
    assign s_axi_arready        = s_r.arready;
    assign s_axi_rvalid         = s_r.rvalid;
    assign s_axi_rdata          = s_r.rdata;
    assign s_axi_rresp          = s_r.rresp;
    assign conv_start           = s_r.conv_start;
    assign converter_power_on   = s_r.pwr;
    assign input_channel_select = s_r.chan;
    assign input_connect        = s_r.connect;
    assign fault_brake          = s_r.fault_brake;
    assign irq                  = s_r.irq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_brake_cause;
        fault_brake |-> s_r.cmp_res && s_r.brake_en;
    endproperty
    a_brake_cause: assert property (p_brake_cause) else $error("brake without compare hit"); // R1

    property p_cmp_ge;
        s_r.fsm == ACC_CONV && conv_complete && s_r.pwr && s_r.cmp_en && !s_r.pol
            |=> s_r.cmp_res == ($past(conversion_result) >= s_r.thresh);
    endproperty
    a_cmp_ge: assert property (p_cmp_ge) else $error("compare result wrong"); // R2

    property p_cmp_off;
        s_r.fsm == ACC_CONV && conv_complete && s_r.pwr && !s_r.cmp_en |=> !s_r.cmp_res;
    endproperty
    a_cmp_off: assert property (p_cmp_off) else $error("disabled comparator hit"); // R3

    property p_done_set;
        s_r.fsm == ACC_CONV && conv_complete && s_r.pwr |=> s_r.done && !s_r.busy;
    endproperty
    a_done_set: assert property (p_done_set) else $error("completion not recorded"); // R9

    property p_no_start_done;
        s_r.done |=> !conv_start;
    endproperty
    a_no_start_done: assert property (p_no_start_done) else $error("start while done"); // R7

    property p_delay_zero;
        trig_fire && s_r.fsm == ACC_IDLE && !sw_start && s_r.dly == '0 |=> conv_start;
    endproperty
    a_delay_zero: assert property (p_delay_zero) else $error("zero delay start late"); // R17

    property p_disconnect;
        !converter_power_on |-> !input_connect;
    endproperty
    a_disconnect: assert property (p_disconnect) else $error("input connected while off"); // R12

    property p_brake_pulse;
        fault_brake |=> !fault_brake;
    endproperty
    a_brake_pulse: assert property (p_brake_pulse) else $error("brake longer than one cycle"); // R18

    property p_ignore_busy;
        s_r.busy && s_r.fsm != ACC_DELAY |=> !conv_start;
    endproperty
    a_ignore_busy: assert property (p_ignore_busy) else $error("trigger taken while busy"); // R15
endmodule : acc_conversion_control

//--- acc_conv_model.sv
// Purpose: Behavioural converter macro that answers each start pulse.
// Assumes: One start at a time; the bench sets the result value.
// Notes:   Result bus shows the inverted value outside the done pulse.
`timescale 1ns/1ps
module acc_conv_model
#(
    parameter int LAT = 12
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        conv_start,
    input  wire logic [11:0] value,
    output logic             conv_complete,
    output logic [11:0]      conversion_result
);
    int cnt_r;
    always @(posedge aclk)
    begin
        conv_complete <= aresetn && cnt_r == 1 && !conv_start;
        conversion_result <= (cnt_r == 1) ? value : ~value;
        if (!aresetn)
            cnt_r <= 0;
        else if (conv_start)
            cnt_r <= LAT;
        else if (cnt_r != 0)
            cnt_r <= cnt_r - 1;
    end
endmodule : acc_conv_model

//--- acc_conversion_control_tb_top.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: Converter answers a start after a fixed latency.
// Notes:   Trigger inputs are driven as one vector.
`timescale 1ns/1ps
module acc_conversion_control_tb_top;
    import acc_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, conv_complete, conv_start, converter_power_on;
    logic input_connect, fault_brake, irq;
    logic [ACC_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF, input_channel_select;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [5:0] trg = '0;
    logic [11:0] conversion_result, value = '0;
    int miscompares = 0, checks = 0, starts = 0, brakes = 0;
    localparam logic [7:0] RI [8] = '{8'hE1, 8'hE2, 8'hE3, 8'hE8, 8'hF0, 8'hF1, 8'hF2, 8'hF3};
    localparam logic [11:0] CR [6] = '{12'h800, 12'h7FF, 12'h7FF, 12'h800, 12'hFFF, 12'h000};
    localparam logic [7:0] C2 [6] = '{8'h30, 8'h20, 8'h60, 8'h70, 8'h10, 8'hE0};
    localparam logic [1:0] ES [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
    localparam logic [1:0] ET [6] = '{2'h1, 2'h1, 2'h1, 2'h0, 2'h2, 2'h3};
    localparam logic [8:0] ED [6] = '{9'h000, 9'h003, 9'h100, 9'h001, 9'h002, 9'h001};

    always #2.5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        if (conv_start === 1'b1) starts++;
        if (fault_brake === 1'b1) brakes++;
    end

    acc_conversion_control acc_conversion_control_i (.*, .pwm_channel_zero(trg[0]), .pwm_channel_two(trg[1]),
        .pwm_channel_four(trg[2]), .ext_start_pin(trg[3]), .pwm_centre_point(trg[4]), .pwm_end_point(trg[5]));
    acc_conv_model #(.LAT(12)) acc_conv_model_i (.*);

    task automatic end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 0;
        rsp = s_axi_bresp;
    endtask : wr

    task automatic rdr(input logic [7:0] idx);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask : rdr

    task automatic wd;
        repeat (40)
        begin
            rdr(ACC_IDX_CTL_ZERO);
            if (rd[7] === 1'b1) break;
        end
    endtask : wd

    task automatic t_reset;
        foreach (RI[i]) begin rdr(RI[i]); chk(rd, ACC_RST_WORD); chk(rsp, ACC_RESP_OKAY); end
        rdr(8'h10);
        chk(rd, 32'h0);
        chk(rsp, ACC_RESP_SLVERR);
        wr(8'h10, 32'hFF);
        chk(rsp, ACC_RESP_SLVERR);
    endtask : t_reset

    task automatic t_soft;
        wr(ACC_IDX_CTL_ONE, 32'h01);
        wr(ACC_IDX_CTL_ZERO, 32'h46);
        rdr(ACC_IDX_CTL_ZERO);
        chk(rd[7:0], 8'h46);
        chk({input_connect, input_channel_select}, 5'h16);
        wd;
        chk(rd[7:0], 8'h86);
        wr(ACC_IDX_CTL_ZERO, 32'hC6);
        repeat (20) @(posedge aclk);
        chk(starts, 1);
        wr(ACC_IDX_CTL_ZERO, 32'h06);
        rdr(ACC_IDX_CTL_ZERO);
        chk({starts[7:0], rd[7:0]}, 16'h0106);
    endtask : t_soft

    task automatic t_cmp;
        wr(ACC_IDX_IRQ_MASK, 32'h0);
        wr(ACC_IDX_THRESH, 32'h800);
        foreach (CR[i])
        begin
            value <= CR[i];
            wr(ACC_IDX_CTL_TWO, C2[i]);
            wr(ACC_IDX_CTL_ZERO, 32'h40);
            wd;
            rdr(ACC_IDX_CTL_TWO);
            chk(rd[4], (i == 0 || i == 2 || i == 5));
            rdr(ACC_IDX_RESULT);
            chk({brakes[3:0], rd[11:0]}, {(i == 5) ? 4'h1 : 4'h0, CR[i]});
            wr(ACC_IDX_CTL_ZERO, 32'h0);
        end
        chk(irq, 1'b0);
        wr(ACC_IDX_IRQ_MASK, 32'h2);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b1);
        rdr(ACC_IDX_IRQ_STAT);
        repeat (2) @(posedge aclk);
        chk({rd[1], irq}, 2'b10);
    endtask : t_cmp

    task automatic ext(input logic [1:0] src, input logic [1:0] typ, input logic [8:0] dly);
        int k;
        int n;
        int s0;
        k = typ[1] ? typ + 2 : src;
        wr(ACC_IDX_DLY_LOW, dly[7:0]);
        wr(ACC_IDX_CTL_TWO, dly[8]);
        wr(ACC_IDX_CTL_ONE, {typ, 2'b11});
        wr(ACC_IDX_CTL_ZERO, src << 4);
        trg[k] <= (typ == 2'h0);
        repeat (3) @(posedge aclk);
        trg[k] <= (typ != 2'h0);
        s0 = starts;
        n = 0;
        while (conv_start !== 1'b1 && n < 400)
        begin
            @(posedge aclk);
            n++;
            if (n == 1 && typ[1]) trg[k] <= 1'b0;
        end
        chk(n, dly + 2);
        repeat (2) begin @(posedge aclk); trg[k] <= ~trg[k]; end
        wd;
        chk(starts, s0 + 1);
        wr(ACC_IDX_CTL_ZERO, src << 4);
        trg <= '0;
    endtask : ext

    task automatic t_pwr;
        wr(ACC_IDX_CTL_ONE, 32'h01);
        trg[0] <= 1;
        repeat (20) @(posedge aclk);
        trg[0] <= 0;
        chk(starts, 13);
        wr(ACC_IDX_CTL_ZERO, 32'h09);
        repeat (2) @(posedge aclk);
        chk(input_connect, 1'b0);
        wr(ACC_IDX_CTL_ZERO, 32'h08);
        repeat (2) @(posedge aclk);
        chk({input_connect, input_channel_select}, 5'h18);
        wr(ACC_IDX_CTL_ONE, 32'h0);
        wr(ACC_IDX_CTL_ZERO, 32'h48);
        repeat (20) @(posedge aclk);
        chk({converter_power_on, input_connect, starts[3:0]}, 6'h0D);
    endtask : t_pwr

    initial
    begin
        #200000;
        miscompares++;
        end_sim;
    end

    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        t_reset;
        t_soft;
        t_cmp;
        foreach (ES[i]) ext(ES[i], ET[i], ED[i]);
        t_pwr;
        end_sim;
    end
endmodule : acc_conversion_control_tb_top
